// ===== eovef_core.sv
`timescale 1ns/1ps
//
// Behaviour
// - with exiting enabled, guest enclave ops are checked for a VM exit.
// - exiting disabled at VM entry lets every leaf run without exit.
// - with exiting enabled the 64-bit per-leaf bitmap decides each leaf 0-63; higher leaves never exit.
// - a set bitmap bit for the leaf causes a VM exit.
// - privilege fault outranks the bitmap exit.
// - the bitmap field exists only when exiting enable can be set.
// - without enclave support capability reports exiting enable cannot be 1.
// - without enclave support, VM entry with exiting enable set fails.
// - without enclave support, field read or write of bitmap fails.
// - primary control bit 31 clear forces exiting enable to act as 0; the code does so for ops only, the entry-fail check still reads raw bit 15.
// - exit reason holds basic reason in 15:0, enclave interruption at 27.
// - enclave-op exit reports basic exit reason 60.
// - interruptibility holds four blocking flags at bits 0-3, enclave flag bit 4.
// - exit from inside an enclave sets exit bit 27 and interruptibility bit 4.
// - failed-entry exit clears bit 27 and leaves interruptibility bit 4 alone.
module eovef_core (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // configuration
  input wire logic enclave_supported,
  input wire logic [31:0] primary_controls,
  // capability report
  output logic cap_exit_en_allowed,
  // control-field access
  input wire logic field_req,
  input wire logic field_wr,
  input wire logic [15:0] field_enc,
  input wire logic [63:0] field_wdata,
  output logic field_ack,
  output logic field_fail,
  output logic [63:0] field_rdata,
  // vm entry
  input wire logic entry_req,
  output logic entry_done,
  output logic entry_fail,
  output logic guest_active,
  // enclave system op in guest
  input wire logic op_req,
  input wire logic [31:0] op_leaf,
  input wire logic [1:0] op_priv_level,
  output logic op_done,
  output logic op_execute,
  output logic op_priv_fault,
  output logic op_vm_exit,
  // other vm exits
  input wire logic exit_req,
  input wire logic [15:0] exit_basic_reason,
  input wire logic exit_in_enclave,
  input wire logic exit_failed_entry,
  output logic exit_done,
  output logic [31:0] exit_reason_out,
  output logic [31:0] guest_intr_out
);
  logic [63:0] bitmap_r;
  logic [31:0] guest_intr_r;
  logic [31:0] sec_ctrl_r;
  logic [31:0] exit_reason_r;
  logic exit_en_latched_r;
  logic guest_active_r;
  logic cap_r;
  logic field_ack_r;
  logic field_fail_r;
  logic [63:0] field_rdata_r;
  logic entry_done_r;
  logic entry_fail_r;
  logic op_done_r;
  logic op_execute_r;
  logic op_priv_fault_r;
  logic op_vm_exit_r;
  logic exit_done_r;
  logic sec_exit_en_eff;
  logic entry_bad;
  logic op_take;
  logic op_exits;
  logic fld_bitmap;
  logic fld_intr;
  logic fld_sec;
  logic fld_xr;
  logic fld_hit_ok;
  logic [63:0] fld_rd_nxt;
  logic intr_write;
  logic sec_write;
  logic [31:0] exit_reason_nxt;
  logic [31:0] guest_intr_nxt;

  eovef_leaf_if lf ();

  eovef_leaf_filter eovef_leaf_filter_i (
    .lf(lf)
  );

  // effective enable as seen at entry time
  assign sec_exit_en_eff = sec_ctrl_r[eovef_pkg::SEC_EXIT_EN_BIT]
    && primary_controls[eovef_pkg::PRI_SEC_ACT_BIT];
  assign entry_bad = !enclave_supported
    && sec_ctrl_r[eovef_pkg::SEC_EXIT_EN_BIT];

  // the filter sees the enable captured at entry, not the live field
  assign lf.leaf = op_leaf;
  assign lf.priv_level = op_priv_level;
  assign lf.bitmap = bitmap_r;
  assign lf.exit_en = exit_en_latched_r;

  // ops only count while the guest runs; a same-cycle exit report takes priority
  assign op_take = op_req && guest_active_r && !exit_req;
  assign op_exits = op_take && lf.bitmap_exit;

  // field decode
  assign fld_bitmap = (field_enc == eovef_pkg::FLD_EXIT_BITMAP) && enclave_supported;
  assign fld_intr = (field_enc == eovef_pkg::FLD_GUEST_INTR);
  assign fld_sec = (field_enc == eovef_pkg::FLD_SEC_CTRL);
  assign fld_xr = (field_enc == eovef_pkg::FLD_EXIT_REASON);
  // exit reason is read-only; writes to it fail
  assign fld_hit_ok = fld_bitmap || fld_intr || fld_sec || (fld_xr && !field_wr);
  assign intr_write = field_req && field_wr && fld_intr;
  assign sec_write = field_req && field_wr && fld_sec;

  always_comb begin
    fld_rd_nxt = 64'h0;
    if (fld_bitmap) begin
      fld_rd_nxt = bitmap_r;
    end else if (fld_intr) begin
      fld_rd_nxt = {32'h0, guest_intr_r};
    end else if (fld_sec) begin
      fld_rd_nxt = {32'h0, sec_ctrl_r};
    end else if (fld_xr) begin
      fld_rd_nxt = {32'h0, exit_reason_r};
    end
  end

  // exit reporting: reason word and enclave interruption flags
  always_comb begin
    exit_reason_nxt = exit_reason_r;
    guest_intr_nxt = intr_write ? field_wdata[31:0] : guest_intr_r;
    if (exit_req) begin
      exit_reason_nxt = 32'h0;
      exit_reason_nxt[eovef_pkg::XR_BASIC_LSB +: eovef_pkg::XR_BASIC_W] =
        exit_basic_reason;
      if (exit_failed_entry) begin
        // guest state untouched, so bit 4 keeps its old value
        exit_reason_nxt[eovef_pkg::XR_ENCL_BIT] = 1'b0;
      end else begin
        exit_reason_nxt[eovef_pkg::XR_ENCL_BIT] = exit_in_enclave;
        guest_intr_nxt[eovef_pkg::GI_ENCL_BIT] = exit_in_enclave;
      end
    end else if (op_exits) begin
      // the op itself runs outside any enclave
      exit_reason_nxt = 32'h0;
      exit_reason_nxt[eovef_pkg::XR_BASIC_LSB +: eovef_pkg::XR_BASIC_W] =
        eovef_pkg::XR_ENCLAVE_OP;
      guest_intr_nxt[eovef_pkg::GI_ENCL_BIT] = 1'b0;
    end
  end

  // control fields
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      bitmap_r <= eovef_pkg::BITMAP_RST;
    end else if (field_req && field_wr && fld_bitmap) begin
      bitmap_r <= field_wdata;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sec_ctrl_r <= eovef_pkg::SEC_CTRL_RST;
    end else if (sec_write) begin
      sec_ctrl_r <= field_wdata[31:0];
    end
  end

  // hardware update wins over a same-cycle software write of the flag
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      guest_intr_r <= eovef_pkg::GUEST_INTR_RST;
    end else begin
      guest_intr_r <= guest_intr_nxt;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      exit_reason_r <= eovef_pkg::EXIT_REASON_RST;
    end else begin
      exit_reason_r <= exit_reason_nxt;
    end
  end

  // field access answer, one cycle after the request
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      field_ack_r <= 1'b0;
      field_fail_r <= 1'b0;
      field_rdata_r <= 64'h0;
    end else begin
      field_ack_r <= field_req;
      field_fail_r <= field_req && !fld_hit_ok;
      field_rdata_r <= (field_req && !field_wr && fld_hit_ok) ? fld_rd_nxt : 64'h0;
    end
  end

  // vm entry: capture the effective enable for the whole guest run
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      entry_done_r <= 1'b0;
      entry_fail_r <= 1'b0;
    end else begin
      entry_done_r <= entry_req && !guest_active_r;
      entry_fail_r <= entry_req && !guest_active_r && entry_bad;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      guest_active_r <= 1'b0;
    end else if (exit_req || op_exits) begin
      guest_active_r <= 1'b0;
    end else if (entry_req && !guest_active_r && !entry_bad) begin
      guest_active_r <= 1'b1;
    end
  end

  // held for the whole run, so a mid-run write only counts from the next entry
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      exit_en_latched_r <= 1'b0;
    end else if (entry_req && !guest_active_r && !entry_bad && !exit_req) begin
      exit_en_latched_r <= sec_exit_en_eff;
    end
  end

  // enclave op verdict, one cycle after the request
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      op_done_r <= 1'b0;
      op_execute_r <= 1'b0;
      op_priv_fault_r <= 1'b0;
      op_vm_exit_r <= 1'b0;
    end else begin
      op_done_r <= op_take;
      op_priv_fault_r <= op_take && lf.priv_fault;
      op_vm_exit_r <= op_exits;
      op_execute_r <= op_take && !lf.priv_fault && !lf.bitmap_exit;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      exit_done_r <= 1'b0;
    end else begin
      exit_done_r <= exit_req || op_exits;
    end
  end

  // a part without enclave support never offers the 1-setting
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cap_r <= 1'b0;
    end else begin
      cap_r <= enclave_supported;
    end
  end

  assign cap_exit_en_allowed = cap_r;
  assign field_ack = field_ack_r;
  assign field_fail = field_fail_r;
  assign field_rdata = field_rdata_r;
  assign entry_done = entry_done_r;
  assign entry_fail = entry_fail_r;
  assign guest_active = guest_active_r;
  assign op_done = op_done_r;
  assign op_execute = op_execute_r;
  assign op_priv_fault = op_priv_fault_r;
  assign op_vm_exit = op_vm_exit_r;
  assign exit_done = exit_done_r;
  assign exit_reason_out = exit_reason_r;
  assign guest_intr_out = guest_intr_r;
endmodule : eovef_core

// ===== eovef_core_assertions.sv
`timescale 1ns/1ps
module eovef_core_assertions (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // requests
  input wire logic enclave_supported,
  input wire logic field_req,
  input wire logic field_wr,
  input wire logic [15:0] field_enc,
  input wire logic op_req,
  input wire logic [31:0] op_leaf,
  input wire logic [1:0] op_priv_level,
  input wire logic exit_req,
  input wire logic [15:0] exit_basic_reason,
  input wire logic exit_in_enclave,
  input wire logic exit_failed_entry,
  // answers
  input wire logic cap_exit_en_allowed,
  input wire logic field_fail,
  input wire logic [63:0] field_rdata,
  input wire logic entry_fail,
  input wire logic guest_active,
  input wire logic op_done,
  input wire logic op_execute,
  input wire logic op_priv_fault,
  input wire logic op_vm_exit,
  input wire logic exit_done,
  input wire logic [31:0] exit_reason_out,
  input wire logic [31:0] guest_intr_out
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  logic op_take;
  // exit_req wins over a same-cycle op, so it is not a taken op
  assign op_take = op_req && guest_active && !exit_req;
  AST_CAP: assert property (!$past(reset) |-> cap_exit_en_allowed == $past(enclave_supported))
    else $error("capability mismatch");
  AST_BMP_FAIL: assert property (field_req && field_enc == eovef_pkg::FLD_EXIT_BITMAP
    && !enclave_supported |=> field_fail && field_rdata == 64'h0) else $error("bitmap access ok");
  AST_PRIV: assert property (op_take && op_priv_level != eovef_pkg::PRIV_RING0
    |=> op_priv_fault)
    else $error("no privilege fault");
  AST_BIG_LEAF: assert property (op_take && op_priv_level == 2'h0 && op_leaf[31:6] != 26'h0
    |=> op_done && op_execute) else $error("high leaf not executed");
  AST_OP_REASON: assert property (op_vm_exit |-> exit_done && !guest_active
    && exit_reason_out[15:0] == eovef_pkg::XR_ENCLAVE_OP) else $error("op exit reason");
  AST_ONE_VERDICT: assert property (op_done |-> $onehot({op_execute, op_priv_fault, op_vm_exit}))
    else $error("verdict not one-hot");
  AST_BASIC: assert property (exit_req |=> exit_done
    && exit_reason_out[15:0] == $past(exit_basic_reason)) else $error("basic reason");
  AST_ENCL: assert property (exit_req && exit_in_enclave && !exit_failed_entry
    |=> exit_reason_out[27] && guest_intr_out[4]) else $error("enclave flags not set");
  AST_FAILED: assert property (exit_req && exit_failed_entry && !(field_req && field_wr)
    |=> !exit_reason_out[27] && $stable(guest_intr_out[4])) else $error("failed entry flags");
  AST_ENTRY_FAIL: assert property (entry_fail |-> !guest_active && !$past(enclave_supported))
    else $error("entry fail");
endmodule : eovef_core_assertions
bind eovef_core eovef_core_assertions eovef_core_assertions_i (.clock, .reset,
  .enclave_supported, .field_req, .field_wr, .field_enc, .op_req, .op_leaf, .op_priv_level,
  .exit_req, .exit_basic_reason, .exit_in_enclave, .exit_failed_entry, .cap_exit_en_allowed,
  .field_fail, .field_rdata, .entry_fail, .guest_active, .op_done, .op_execute,
  .op_priv_fault, .op_vm_exit, .exit_done, .exit_reason_out, .guest_intr_out);

// ===== eovef_core_bench.sv
`timescale 1ns/1ps
module eovef_core_bench;
  logic clock, reset, enclave_supported, field_req, field_wr, entry_req, op_req, g;
  logic exit_req, exit_in_enclave, exit_failed_entry, cap_exit_en_allowed, field_ack;
  logic field_fail, entry_done, entry_fail, guest_active, op_done, op_execute;
  logic op_priv_fault, op_vm_exit, exit_done;
  logic [31:0] primary_controls, op_leaf, exit_reason_out, guest_intr_out, lfsr, gi, lf;
  logic [15:0] field_enc, exit_basic_reason;
  logic [63:0] field_wdata, field_rdata, bmp;
  logic [1:0] op_priv_level;
  logic [71:0] expq[$];
  int fails, num_checks;
  eovef_core eovef_core_i (.clock, .reset, .enclave_supported, .primary_controls,
    .cap_exit_en_allowed, .field_req, .field_wr, .field_enc, .field_wdata, .field_ack,
    .field_fail, .field_rdata, .entry_req, .entry_done, .entry_fail, .guest_active,
    .op_req, .op_leaf, .op_priv_level, .op_done, .op_execute, .op_priv_fault, .op_vm_exit,
    .exit_req, .exit_basic_reason, .exit_in_enclave, .exit_failed_entry, .exit_done,
    .exit_reason_out, .guest_intr_out);
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd
  task automatic check(input logic [71:0] seen, input logic [71:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report();
    if (fails == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  // a spare edge after each pulse keeps a strobe from being set twice in one step
  task automatic tick();
    @(posedge clock);
    #1;
  endtask : tick
  task automatic fld(input logic w, input logic [15:0] e, input logic [63:0] d, input logic [64:0] x);
    field_req = 1;
    field_wr = w;
    field_enc = e;
    field_wdata = d;
    expq.push_back(72'({enclave_supported, x}));
    tick();
    field_req = 0;
    tick();
  endtask : fld
  task automatic ent(input logic [1:0] x);
    entry_req = 1;
    expq.push_back(72'(x));
    tick();
    entry_req = 0;
    tick();
    g = x[0];
  endtask : ent
  task automatic op(input logic [31:0] l, input logic [1:0] c, input logic [2:0] x);
    op_req = 1;
    op_leaf = l;
    op_priv_level = c;
    expq.push_back(72'({x, x[0] ? 16'h003c : 16'h0}));
    if (x[0]) begin
      g = 0;
      gi[4] = 0;
    end
    tick();
    op_req = 0;
    tick();
  endtask : op
  task automatic ex(input logic [15:0] b, input logic ie, input logic fe);
    exit_req = 1;
    exit_basic_reason = b;
    exit_in_enclave = ie;
    exit_failed_entry = fe;
    if (!fe) gi[4] = ie;
    expq.push_back(72'({4'h0, ie & !fe, 11'h0, b, gi}));
    tick();
    exit_req = 0;
    tick();
    g = 0;
  endtask : ex
  // one note is taken off per answer, in the order the answers show up
  always @(posedge clock) begin
    #1;
    if (field_ack === 1'b1)
      check({cap_exit_en_allowed, field_fail, field_rdata}, expq.pop_front());
    if (entry_done === 1'b1) check({entry_fail, guest_active}, expq.pop_front());
    if (op_done === 1'b1)
      check({op_execute, op_priv_fault, op_vm_exit, op_vm_exit ? exit_reason_out[15:0] : 16'h0},
        expq.pop_front());
    else if (exit_done === 1'b1) check({exit_reason_out, guest_intr_out}, expq.pop_front());
  end
  initial begin
    clock = 0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    #200000;
    fails++;
    final_report();
  end
  initial begin
    {reset, enclave_supported, g} = 3'b110;
    primary_controls = 32'h80000000;
    {field_req, field_wr, entry_req, op_req, exit_req, exit_in_enclave, exit_failed_entry} = 0;
    {field_enc, exit_basic_reason, field_wdata, op_leaf, op_priv_level} = 0;
    {lfsr, gi} = {32'h8bc2, 32'h0};
    {fails, num_checks} = 0;
    repeat (6) @(posedge clock);
    #1 reset = 0;
    fld(0, eovef_pkg::FLD_EXIT_BITMAP, 0, 0);
    fld(0, eovef_pkg::FLD_GUEST_INTR, 0, 0);
    fld(0, 16'h1234, 0, {1'b1, 64'h0});
    fld(1, eovef_pkg::FLD_EXIT_REASON, 1, {1'b1, 64'h0});
    bmp = {rnd(), rnd()};
    fld(1, eovef_pkg::FLD_EXIT_BITMAP, bmp, 0);
    fld(0, eovef_pkg::FLD_EXIT_BITMAP, 0, {1'b0, bmp});
    ent(2'b01);
    for (int i = 0; i < 4; i++) op(rnd() & 32'h3f, 0, 3'b100);
    ex(16'(rnd()), 0, 0);
    fld(1, eovef_pkg::FLD_SEC_CTRL, 64'h8000, 0);
    for (int i = 0; i < 16; i++) begin
      lf = rnd() & 32'h3f;
      if (!g) ent(2'b01);
      if (i == 3) op(lf, 2'h3, 3'b010);
      else if (i == 5) op(lf | 32'h40, 0, 3'b100);
      else op(lf, 0, bmp[lf[5:0]] ? 3'b001 : 3'b100);
    end
    if (g) ex(16'h1, 0, 0);
    fld(1, eovef_pkg::FLD_EXIT_BITMAP, '1, 0);
    ent(2'b01);
    op(9, 2'h1, 3'b010);
    op(9, 0, 3'b001);
    primary_controls = 0;
    ent(2'b01);
    op(7, 0, 3'b100);
    // an op in the same cycle as an exit report must be ignored
    op_req = 1;
    ex(16'h21, 1, 0);
    op_req = 0;
    fld(1, eovef_pkg::FLD_GUEST_INTR, 64'h1f, 0);
    gi = 32'h1f;
    fld(0, eovef_pkg::FLD_GUEST_INTR, 0, {1'b0, 64'h1f});
    ex(16'h22, 1, 1);
    ex(16'h23, 0, 0);
    enclave_supported = 0;
    primary_controls = 32'h80000000;
    tick();
    fld(0, eovef_pkg::FLD_EXIT_BITMAP, 0, {1'b1, 64'h0});
    fld(1, eovef_pkg::FLD_EXIT_BITMAP, 1, {1'b1, 64'h0});
    ent(2'b10);
    fld(1, eovef_pkg::FLD_SEC_CTRL, 0, 0);
    ent(2'b01);
    for (int i = 0; i < 20 && expq.size() > 0; i++) tick();
    if (expq.size() > 0) fails++;
    final_report();
  end
endmodule : eovef_core_bench

// ===== eovef_leaf_filter.sv
`timescale 1ns/1ps
module eovef_leaf_filter (
  // decision request and verdict
  eovef_leaf_if.filter lf
);
  logic leaf_in_map;
  logic leaf_bit;

  // leaves beyond the bitmap have no bit, so they never exit by the bitmap
  assign leaf_in_map = (lf.leaf[31:eovef_pkg::LEAF_BITS] == '0);
  assign leaf_bit = lf.bitmap[lf.leaf[eovef_pkg::LEAF_BITS-1:0]];
  assign lf.priv_fault = (lf.priv_level != eovef_pkg::PRIV_RING0);
  // privilege check first, bitmap only when it passes
  assign lf.bitmap_exit = !lf.priv_fault && lf.exit_en && leaf_in_map && leaf_bit;
endmodule : eovef_leaf_filter

// ===== eovef_leaf_if.sv
`timescale 1ns/1ps
interface eovef_leaf_if;
  logic [31:0] leaf;
  logic [1:0] priv_level;
  logic [63:0] bitmap;
  logic exit_en;
  logic priv_fault;
  logic bitmap_exit;
  modport core (
    output leaf,
    output priv_level,
    output bitmap,
    output exit_en,
    input priv_fault,
    input bitmap_exit
  );
  modport filter (
    input leaf,
    input priv_level,
    input bitmap,
    input exit_en,
    output priv_fault,
    output bitmap_exit
  );
endinterface : eovef_leaf_if

// ===== eovef_pkg.sv
package eovef_pkg;
  // field encodings on the control-field access port
  localparam logic [15:0] FLD_EXIT_BITMAP = 16'h202e;
  localparam logic [15:0] FLD_GUEST_INTR = 16'h4824;
  localparam logic [15:0] FLD_SEC_CTRL = 16'h4100;
  localparam logic [15:0] FLD_EXIT_REASON = 16'h4400;
  // secondary and primary execution controls
  localparam int SEC_EXIT_EN_BIT = 15;
  localparam int PRI_SEC_ACT_BIT = 31;
  // exit-reason word layout
  localparam int XR_BASIC_LSB = 0;
  localparam int XR_BASIC_W = 16;
  localparam int XR_ENCL_BIT = 27;
  localparam logic [15:0] XR_ENCLAVE_OP = 16'h003c;
  // guest interruptibility-state layout
  localparam int GI_IRQ_SHADOW_BIT = 0;
  localparam int GI_STACK_SHADOW_BIT = 1;
  localparam int GI_MGMT_BLOCK_BIT = 2;
  localparam int GI_NMI_BLOCK_BIT = 3;
  localparam int GI_ENCL_BIT = 4;
  // leaf decoding
  localparam int LEAF_BITS = 6;
  localparam int BITMAP_W = 64;
  localparam logic [1:0] PRIV_RING0 = 2'h0;
  // reset values
  localparam logic [63:0] BITMAP_RST = 64'h0;
  localparam logic [31:0] GUEST_INTR_RST = 32'h0;
  localparam logic [31:0] SEC_CTRL_RST = 32'h0;
  localparam logic [31:0] EXIT_REASON_RST = 32'h0;
endpackage : eovef_pkg
